// ### common/sts_pkg.sv
// shared constants for the speed trip set-up logic
package sts_pkg;

    // ********************************
    // clock and blink timing
    // ********************************
    localparam int unsigned CLK_KHZ = 20000;
    localparam int unsigned HALF_SEC_MS = 500;
    localparam int unsigned FLASH_MS = 40;
    localparam int unsigned ZERO_OFF_MS = 1000;
    localparam int unsigned DIGIT_GAP_MS = 2000;
    localparam int unsigned END_GAP_MS = 4000;
    localparam int unsigned RAPID_MS = 100;

    // ********************************
    // set-up sections on the three select switches
    // ********************************
    localparam logic [2:0] SEC_FREQ = 3'h2;
    localparam logic [2:0] SEC_RESP = 3'h3;
    localparam logic [2:0] SEC_OFFS = 3'h4;
    localparam logic [2:0] SEC_HYST = 3'h5;

    // ********************************
    // value limits, frequencies in millihertz
    // ********************************
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] RESP_LONG_MIN = 4'h8;
    localparam logic [31:0] FREQ_MIN_MHZ = 32'h0000_0064;
    localparam logic [31:0] FREQ_MAX_MHZ = 32'h017d_7840;
    localparam logic [31:0] RESP_LONG_MAX_MHZ = 32'h003b_99d0;
    localparam logic [13:0] FRAC_DEN = 14'h2710;
    localparam logic [2:0] LAST_DIGIT = 3'h5;

    // ********************************
    // factory settings
    // ********************************
    localparam logic [23:0] DEF_DIGITS = 24'h100000;
    localparam logic [3:0] DEF_RESP = 4'h0;
    localparam logic [3:0] DEF_OFFS = 4'h0;
    localparam logic [3:0] DEF_HYST = 4'h1;

    // ********************************
    // apb register map
    // ********************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_TRIP = 12'h008;
    localparam logic [11:0] ADDR_RELEASE = 12'h00c;
    localparam logic [11:0] ADDR_DIGITS = 12'h010;
    localparam logic [11:0] ADDR_CODES = 12'h014;
    localparam int unsigned CTRL_UNDER_BIT = 0;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SHOW = 3'b010,
        ST_EDIT = 3'b100
    } sts_state_t;

    typedef enum logic [3:0] {
        BL_START = 4'b0001,
        BL_ON = 4'b0010,
        BL_OFF = 4'b0100,
        BL_GAP = 4'b1000
    } sts_blink_t;

endpackage

// ### rtl/sts_setup_top.sv
// set-up entry, blink display, trip/release computation and relay for the speed trip controller
`timescale 1ns/1ps

module sts_setup_top #(
    parameter int unsigned HALF_CYC = sts_pkg::HALF_SEC_MS * sts_pkg::CLK_KHZ,
    parameter int unsigned FLASH_CYC = sts_pkg::FLASH_MS * sts_pkg::CLK_KHZ,
    parameter int unsigned ZERO_OFF_CYC = sts_pkg::ZERO_OFF_MS * sts_pkg::CLK_KHZ,
    parameter int unsigned DIGIT_GAP_CYC = sts_pkg::DIGIT_GAP_MS * sts_pkg::CLK_KHZ,
    parameter int unsigned END_GAP_CYC = sts_pkg::END_GAP_MS * sts_pkg::CLK_KHZ,
    parameter int unsigned RAPID_CYC = sts_pkg::RAPID_MS * sts_pkg::CLK_KHZ
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic setup_selector_switch_i,
    input wire logic [2:0] section_sel_i,
    input wire logic [3:0] rotary_i,
    input wire logic button_i,
    input wire logic [31:0] meas_freq_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic green_led_o,
    output logic red_led_o,
    output logic relay_o,
    output logic [13:0] resp_ms_o
);

    // ********************************
    // parameter checks
    // ********************************
    if (HALF_CYC < 1 || FLASH_CYC < 1 || ZERO_OFF_CYC < 1 || DIGIT_GAP_CYC < 1 ||
        END_GAP_CYC < 1 || RAPID_CYC < 1) begin : g_bad_timing
        $error("sts_setup_top: every timing count must be at least one cycle");
    end

    // ********************************
    // helper functions
    // ********************************
    function automatic logic [3:0] digit_at(input logic [23:0] d, input logic [2:0] idx);
        digit_at = d[5'(20 - 4 * idx) +: 4];
    endfunction

    // digits to millihertz; resolutions above five can never reach 0.1 Hz
    function automatic logic [32:0] to_mhz(input logic [23:0] d);
        logic [31:0] mag;
        logic [32:0] res;
        mag = 32'(d[23:20]) * 32'd10000 + 32'(d[19:16]) * 32'd1000 +
              32'(d[15:12]) * 32'd100 + 32'(d[11:8]) * 32'd10 + 32'(d[7:4]);
        res = 33'h0;
        case (d[3:0])
            4'h0: res = {1'b1, 32'(mag * 32'd1000)};
            4'h1: res = {1'b1, 32'(mag * 32'd100)};
            4'h2: res = {1'b1, 32'(mag * 32'd10)};
            4'h3: res = {1'b1, mag};
            4'h4: res = {1'b1, 32'(mag / 32'd10)};
            4'h5: res = {1'b1, 32'(mag / 32'd100)};
            default: res = 33'h0;
        endcase
        to_mhz = res;
    endfunction

    function automatic logic digits_ok(input logic [23:0] d);
        logic ok;
        logic [32:0] f;
        ok = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (d[4 * i +: 4] > sts_pkg::DIGIT_MAX) begin
                ok = 1'b0;
            end
        end
        f = to_mhz(d);
        digits_ok = ok && f[32] && f[31:0] >= sts_pkg::FREQ_MIN_MHZ &&
                    f[31:0] <= sts_pkg::FREQ_MAX_MHZ;
    endfunction

    // fraction in units of 1/10000, shared by offset and hysteresis
    function automatic logic [13:0] frac_of(input logic [3:0] code);
        case (code)
            4'h1: frac_of = 14'h0019;
            4'h2: frac_of = 14'h0032;
            4'h3: frac_of = 14'h0064;
            4'h4: frac_of = 14'h00c8;
            4'h5: frac_of = 14'h01f4;
            4'h6: frac_of = 14'h03e8;
            4'h7: frac_of = 14'h07d0;
            4'h8: frac_of = 14'h09c4;
            4'h9: frac_of = 14'h0d05;
            default: frac_of = 14'h0000;
        endcase
    endfunction

    function automatic logic [31:0] part_of(input logic [31:0] f, input logic [3:0] code);
        logic [45:0] prod;
        prod = 46'(f) * 46'(frac_of(code));
        part_of = 32'(prod / 46'(sts_pkg::FRAC_DEN));
    endfunction

    function automatic logic [13:0] resp_ms(input logic [3:0] code);
        case (code)
            4'h1: resp_ms = 14'h000a;
            4'h2: resp_ms = 14'h0014;
            4'h3: resp_ms = 14'h0032;
            4'h4: resp_ms = 14'h0064;
            4'h5: resp_ms = 14'h00c8;
            4'h6: resp_ms = 14'h01f4;
            4'h7: resp_ms = 14'h03e8;
            4'h8: resp_ms = 14'h1388;
            4'h9: resp_ms = 14'h2710;
            default: resp_ms = 14'h0005;
        endcase
    endfunction

    // ********************************
    // switch and button synchronisers
    // ********************************
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    logic setup_s;
    logic [2:0] sec_s;
    logic [3:0] rot_s;
    logic btn_s;
    logic btn_prev_q;
    logic [2:0] sec_prev_q;
    logic setup_prev_q;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
        end else begin
            sync1_q <= {setup_selector_switch_i, section_sel_i, rotary_i, button_i};
            sync2_q <= sync1_q;
        end
    end

    assign setup_s = sync2_q[8];
    assign sec_s = sync2_q[7:5];
    assign rot_s = sync2_q[4:1];
    assign btn_s = sync2_q[0];

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            btn_prev_q <= 1'b0;
            sec_prev_q <= 3'h0;
            setup_prev_q <= 1'b0;
        end else begin
            btn_prev_q <= btn_s;
            sec_prev_q <= sec_s;
            setup_prev_q <= setup_s;
        end
    end

    // ********************************
    // set-up state machine
    // ********************************
    sts_pkg::sts_state_t state_q;
    logic [2:0] entry_cnt_q;
    logic [23:0] edit_q;
    logic err_q;
    logic [23:0] digits_q;
    logic [3:0] resp_q;
    logic [3:0] offs_q;
    logic [3:0] hyst_q;
    logic [31:0] freq_mhz_w;
    logic press_w;
    logic sw_chg_w;
    logic sec_known_w;
    logic is_freq_w;
    logic [23:0] new_digits_w;
    logic final_w;
    logic entry_ok_w;
    logic commit_w;
    logic bad_w;

    assign freq_mhz_w = 32'(to_mhz(digits_q));
    assign press_w = btn_s & ~btn_prev_q;
    assign sw_chg_w = (sec_s != sec_prev_q) | (setup_s != setup_prev_q);
    assign sec_known_w = (sec_s == sts_pkg::SEC_FREQ) | (sec_s == sts_pkg::SEC_RESP) |
                         (sec_s == sts_pkg::SEC_OFFS) | (sec_s == sts_pkg::SEC_HYST);
    assign is_freq_w = (sec_s == sts_pkg::SEC_FREQ);
    assign new_digits_w = {edit_q[19:0], rot_s};
    assign final_w = ~is_freq_w | (entry_cnt_q == sts_pkg::LAST_DIGIT);
    assign entry_ok_w = is_freq_w ? digits_ok(new_digits_w) :
                        (rot_s <= sts_pkg::DIGIT_MAX) &&
                        !(sec_s == sts_pkg::SEC_RESP && rot_s >= sts_pkg::RESP_LONG_MIN &&
                          freq_mhz_w > sts_pkg::RESP_LONG_MAX_MHZ);
    assign commit_w = (state_q == sts_pkg::ST_EDIT) & press_w & ~sw_chg_w & final_w &
                      entry_ok_w;
    assign bad_w = (state_q == sts_pkg::ST_EDIT) & press_w & ~sw_chg_w & final_w & ~entry_ok_w;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q <= sts_pkg::ST_RUN;
            entry_cnt_q <= 3'h0;
            edit_q <= 24'h000000;
            err_q <= 1'b0;
        end else begin
            case (state_q)
                sts_pkg::ST_RUN: begin
                    if (setup_s) begin
                        state_q <= sts_pkg::ST_SHOW;
                    end
                end
                sts_pkg::ST_SHOW: begin
                    if (!setup_s) begin
                        state_q <= sts_pkg::ST_RUN;
                    end else if (press_w && !sw_chg_w && sec_known_w) begin
                        state_q <= sts_pkg::ST_EDIT;
                        entry_cnt_q <= 3'h0;
                        err_q <= 1'b0;
                    end
                end
                sts_pkg::ST_EDIT: begin
                    if (sw_chg_w || !setup_s) begin
                        state_q <= setup_s ? sts_pkg::ST_SHOW : sts_pkg::ST_RUN;
                        err_q <= 1'b0;
                    end else if (commit_w) begin
                        state_q <= sts_pkg::ST_SHOW;
                        err_q <= 1'b0;
                    end else if (bad_w) begin
                        err_q <= 1'b1;
                        entry_cnt_q <= 3'h0;
                    end else if (press_w) begin
                        edit_q <= new_digits_w;
                        entry_cnt_q <= entry_cnt_q + 3'h1;
                    end
                end
                default: begin
                    state_q <= sts_pkg::ST_RUN;
                end
            endcase
        end
    end

    // committed settings only move on a successful final capture
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            digits_q <= sts_pkg::DEF_DIGITS;
            resp_q <= sts_pkg::DEF_RESP;
            offs_q <= sts_pkg::DEF_OFFS;
            hyst_q <= sts_pkg::DEF_HYST;
        end else if (commit_w) begin
            case (sec_s)
                sts_pkg::SEC_FREQ: digits_q <= new_digits_w;
                sts_pkg::SEC_RESP: resp_q <= rot_s;
                sts_pkg::SEC_OFFS: offs_q <= rot_s;
                sts_pkg::SEC_HYST: hyst_q <= rot_s;
                default: digits_q <= digits_q;
            endcase
        end
    end

    // ********************************
    // digit blinker
    // ********************************
    sts_pkg::sts_blink_t phase_q;
    logic [31:0] timer_q;
    logic [2:0] idx_q;
    logic [3:0] pulses_q;
    logic zero_q;
    logic [3:0] cur_digit_w;
    logic last_w;
    logic restart_w;

    assign restart_w = (state_q != sts_pkg::ST_SHOW) | sw_chg_w;
    assign cur_digit_w = (sec_s == sts_pkg::SEC_FREQ) ? digit_at(digits_q, idx_q) :
                         (sec_s == sts_pkg::SEC_RESP) ? resp_q :
                         (sec_s == sts_pkg::SEC_OFFS) ? offs_q : hyst_q;
    assign last_w = !is_freq_w || idx_q == sts_pkg::LAST_DIGIT;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i || restart_w) begin
            phase_q <= sts_pkg::BL_START;
            timer_q <= 32'h0;
            idx_q <= 3'h0;
            pulses_q <= 4'h0;
            zero_q <= 1'b0;
        end else if (phase_q != sts_pkg::BL_START && timer_q != 32'h0) begin
            timer_q <= timer_q - 32'h1;
        end else begin
            case (phase_q)
                sts_pkg::BL_START: begin
                    phase_q <= sts_pkg::BL_ON;
                    zero_q <= (cur_digit_w == 4'h0);
                    pulses_q <= (cur_digit_w == 4'h0) ? 4'h1 : cur_digit_w;
                    timer_q <= (cur_digit_w == 4'h0) ? 32'(FLASH_CYC - 1) : 32'(HALF_CYC - 1);
                end
                sts_pkg::BL_ON: begin
                    phase_q <= sts_pkg::BL_OFF;
                    timer_q <= zero_q ? 32'(ZERO_OFF_CYC - 1) : 32'(HALF_CYC - 1);
                end
                sts_pkg::BL_OFF: begin
                    pulses_q <= pulses_q - 4'h1;
                    if (pulses_q == 4'h1) begin
                        phase_q <= sts_pkg::BL_GAP;
                        timer_q <= (last_w && is_freq_w) ? 32'(END_GAP_CYC - 1) :
                                   32'(DIGIT_GAP_CYC - 1);
                    end else begin
                        phase_q <= sts_pkg::BL_ON;
                        timer_q <= 32'(HALF_CYC - 1);
                    end
                end
                sts_pkg::BL_GAP: begin
                    phase_q <= sts_pkg::BL_START;
                    idx_q <= last_w ? 3'h0 : idx_q + 3'h1;
                end
                default: begin
                    phase_q <= sts_pkg::BL_START;
                end
            endcase
        end
    end

    // rapid blink marks an open setting
    logic [31:0] rapid_cnt_q;
    logic rapid_q;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rapid_cnt_q <= 32'h0;
            rapid_q <= 1'b0;
        end else if (rapid_cnt_q == 32'(RAPID_CYC - 1)) begin
            rapid_cnt_q <= 32'h0;
            rapid_q <= ~rapid_q;
        end else begin
            rapid_cnt_q <= rapid_cnt_q + 32'h1;
        end
    end

    // ********************************
    // trip and release points, relay
    // ********************************
    logic under_q;
    logic [31:0] trip_pt_q;
    logic [31:0] rel_pt_q;
    logic [31:0] offs_amt_w;
    logic [31:0] hyst_amt_w;
    logic [31:0] trip_w;

    assign offs_amt_w = part_of(freq_mhz_w, offs_q);
    assign hyst_amt_w = part_of(freq_mhz_w, hyst_q);
    assign trip_w = under_q ? freq_mhz_w - offs_amt_w : freq_mhz_w + offs_amt_w;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            trip_pt_q <= 32'h0;
            rel_pt_q <= 32'h0;
        end else begin
            trip_pt_q <= trip_w;
            // code 0 gives a zero amount, so both points coincide
            rel_pt_q <= under_q ? trip_w + hyst_amt_w : trip_w - hyst_amt_w;
        end
    end

    // relay held released during set-up so half-typed settings never act on it
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || state_q != sts_pkg::ST_RUN) begin
            relay_o <= 1'b0;
        end else if (under_q) begin
            if (meas_freq_i < trip_pt_q) begin
                relay_o <= 1'b1;
            end else if (meas_freq_i > rel_pt_q) begin
                relay_o <= 1'b0;
            end
        end else begin
            if (meas_freq_i > trip_pt_q) begin
                relay_o <= 1'b1;
            end else if (meas_freq_i < rel_pt_q) begin
                relay_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            green_led_o <= 1'b0;
            red_led_o <= 1'b0;
            resp_ms_o <= 14'h0005;
        end else begin
            green_led_o <= (state_q == sts_pkg::ST_SHOW && phase_q == sts_pkg::BL_ON) ||
                           (state_q == sts_pkg::ST_EDIT && rapid_q);
            red_led_o <= (state_q == sts_pkg::ST_EDIT) && err_q && !rapid_q;
            resp_ms_o <= resp_ms(resp_q);
        end
    end

    // ********************************
    // apb slave, zero wait, read data latched in setup phase
    // ********************************
    logic setup_ph_w;

    assign setup_ph_w = psel_i & ~penable_i;
    assign pready_o = 1'b1;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            under_q <= 1'b0;
        end else if (psel_i && penable_i && pwrite_i && paddr_i == sts_pkg::ADDR_CTRL) begin
            under_q <= pwdata_i[sts_pkg::CTRL_UNDER_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0;
            pslverr_o <= 1'b0;
        end else if (setup_ph_w) begin
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
            case (paddr_i)
                sts_pkg::ADDR_CTRL: prdata_o <= {31'h0, under_q};
                sts_pkg::ADDR_STATUS: prdata_o <= {27'h0, err_q, state_q, relay_o};
                sts_pkg::ADDR_TRIP: prdata_o <= trip_pt_q;
                sts_pkg::ADDR_RELEASE: prdata_o <= rel_pt_q;
                sts_pkg::ADDR_DIGITS: prdata_o <= {8'h0, digits_q};
                sts_pkg::ADDR_CODES: prdata_o <= {20'h0, hyst_q, offs_q, resp_q};
                default: pslverr_o <= 1'b1;
            endcase
        end
    end

endmodule // sts_setup_top

// ### bench/sts_setup_properties.sv
// assertion checker for the speed trip set-up block
`timescale 1ns/1ps
module sts_setup_checker (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic setup_selector_switch_i,
    input wire logic [31:0] meas_freq_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic green_led_o,
    input wire logic red_led_o,
    input wire logic relay_o,
    input wire logic [13:0] resp_ms_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    AST_RESET_IDLE:
    assert property ($fell(reset_i) |-> !green_led_o && !red_led_o && !relay_o)
        else $error("outputs busy after reset");
    AST_SETUP_NO_RELAY:
    assert property (setup_selector_switch_i [*5] |-> !relay_o) else $error("relay in set-up");
    AST_RESP_TABLE:
    assert property (resp_ms_o inside {5, 10, 20, 50, 100, 200, 500, 1000, 5000, 10000})
        else $error("bad response time");
    AST_LEDS_ALTERNATE:
    assert property (!(green_led_o && red_led_o)) else $error("both indicators lit");
    AST_RELAY_HOLD:
    assert property ((!setup_selector_switch_i && !psel_i && $stable(meas_freq_i)) [*8]
        |-> $stable(relay_o)) else $error("relay moved without cause");
    AST_RUN_KEEPS_RESP:
    assert property (!setup_selector_switch_i [*5] |=> $stable(resp_ms_o))
        else $error("response time changed in run");
    AST_APB_READY:
    assert property (psel_i && penable_i |-> pready_o) else $error("wait state");
    AST_APB_ERROR:
    assert property (psel_i && penable_i |-> pslverr_o == (paddr_i > 12'h014))
        else $error("bad error response");
    cover property ($rose(relay_o));
    cover property ($rose(red_led_o));
    cover property (psel_i && penable_i && pslverr_o);
endmodule // sts_setup_checker

bind sts_setup_top sts_setup_checker chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .setup_selector_switch_i(setup_selector_switch_i), .meas_freq_i(meas_freq_i),
    .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .green_led_o(green_led_o), .red_led_o(red_led_o),
    .relay_o(relay_o), .resp_ms_o(resp_ms_o));

// ### bench/sts_operator.sv
// operator model: set-up switches, rotary selector and push-button
`timescale 1ns/1ps
module sts_operator (
    input wire logic clk_sys_i,
    output logic setup_o = 1'b0,
    output logic [2:0] section_o = 3'h0,
    output logic [3:0] rotary_o = 4'h0,
    output logic button_o = 1'b0
);
    // a human is slow: each move outlasts the input synchroniser
    task automatic switches(input logic on, input logic [2:0] s);
        setup_o <= on;
        section_o <= s;
        repeat (6) @(posedge clk_sys_i);
    endtask
    task automatic press(input logic [3:0] v);
        rotary_o <= v;
        repeat (4) @(posedge clk_sys_i);
        button_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        button_o <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
    endtask
endmodule // sts_operator

// ### bench/testbench.sv
// self-checking bench for the speed trip set-up block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %0t %h %h", $time, g, e); end end
module testbench;
    logic clk_sys_i, reset_i, psel, penable, pwrite;
    logic over = 1'b1, perr, pready, pslv, setup, btn, green, red, relay;
    logic [2:0] sec;
    logic [3:0] rot, rsp = 4'h0, ofs = 4'h0, hys = 4'h1;
    logic [11:0] paddr;
    logic [13:0] resp_ms;
    logic [23:0] dig = 24'h100000, r;
    logic [31:0] pwdata, meas, prdata, rdat;
    int errors = 0, comparisons = 0, seed = 32'h85d8859c;
    longint f = 10000000, tp, rp;
    int msx [10] = '{5, 10, 20, 50, 100, 200, 500, 1000, 5000, 10000};
    int frc [10] = '{0, 25, 50, 100, 200, 500, 1000, 2000, 2500, 3333};
    logic [23:0] fl [8] = '{24'h250010, 24'h000016, 24'h000011, 24'h250000, 24'h250015,
        24'h123454, 24'h000014, 24'h039070};
    localparam int HALF = 10, FLASH = 2, RAPID = 3;
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    sts_operator op (.clk_sys_i(clk_sys_i), .setup_o(setup), .section_o(sec), .rotary_o(rot),
        .button_o(btn));
    sts_setup_top #(.HALF_CYC(HALF), .FLASH_CYC(FLASH), .ZERO_OFF_CYC(5), .DIGIT_GAP_CYC(8),
        .END_GAP_CYC(16), .RAPID_CYC(RAPID)) uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .setup_selector_switch_i(setup), .section_sel_i(sec), .rotary_i(rot), .button_i(btn),
        .meas_freq_i(meas), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslv), .green_led_o(green), .red_led_o(red), .relay_o(relay),
        .resp_ms_o(resp_ms));
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rdat = prdata;
        perr = pslv;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // length in cycles of the next complete green pulse
    task automatic pulse(input int e);
        int n;
        n = 0;
        while (green !== 1'b0) @(posedge clk_sys_i);
        while (green !== 1'b1) @(posedge clk_sys_i);
        while (green === 1'b1) begin
            n++;
            @(posedge clk_sys_i);
        end
        `CHK(n, e)
    endtask
    function automatic longint fmhz(input logic [23:0] d);
        longint m;
        m = 0;
        for (int i = 5; i > 0; i--) m = m * 10 + d[i*4 +: 4];
        if (d[3:0] > 4'h5) return -1;
        m = m * 1000;
        for (int i = 0; i < d[3:0]; i++) m = m / 10;
        return (m < 100 || m > 25000000) ? -1 : m;
    endfunction
    task automatic pts();
        tp = over ? f + f * frc[ofs] / 10000 : f - f * frc[ofs] / 10000;
        rp = over ? tp - f * frc[hys] / 10000 : tp + f * frc[hys] / 10000;
        rd(sts_pkg::ADDR_TRIP, 32'(tp));
        rd(sts_pkg::ADDR_RELEASE, 32'(rp));
    endtask
    task automatic freq(input logic [23:0] d);
        longint v;
        v = fmhz(d);
        op.switches(1'b1, 3'h0);
        op.switches(1'b1, sts_pkg::SEC_FREQ);
        for (int i = 6; i >= 0; i--) op.press(i == 6 ? 4'h0 : d[i*4 +: 4]);
        if (v >= 0) begin
            dig = d;
            f = v;
        end
        rd(sts_pkg::ADDR_STATUS, v >= 0 ? 32'h4 : 32'h18);
        rd(sts_pkg::ADDR_DIGITS, {8'h0, dig});
    endtask
    task automatic code(input logic [2:0] s, input logic [3:0] v, input logic ok);
        op.switches(1'b1, 3'h0);
        op.switches(1'b1, s);
        op.press(4'h0);
        pulse(RAPID);
        op.press(v);
        rd(sts_pkg::ADDR_STATUS, ok ? 32'h4 : 32'h18);
        if (ok) pulse(v == 4'h0 ? FLASH : HALF);
    endtask
    task automatic probe(input longint m, input logic e);
        meas <= 32'(m);
        repeat (6) @(posedge clk_sys_i);
        `CHK(relay, e)
    endtask
    initial begin
        reset_i <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        meas <= 32'h0;
        repeat (12) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(sts_pkg::ADDR_CODES, 32'h100);
        rd(sts_pkg::ADDR_DIGITS, 32'h100000);
        pts();
        rd(12'h020, 32'h0);
        `CHK(perr, 1'b1)
        for (int i = 0; i < 10; i++) begin
            for (int j = 0; j < 6; j++) begin
                r[j*4 +: 4] = 4'($unsigned($random(seed)) % (j ? 10 : 4));
            end
            freq(i < 2 ? r : fl[i - 2]);
        end
        for (int v = 0; v < 10; v++) begin
            code(sts_pkg::SEC_RESP, v[3:0], v < 8);
            if (v < 8) rsp = v[3:0];
            `CHK(resp_ms, 14'(msx[rsp]))
        end
        freq(24'h039060);
        code(sts_pkg::SEC_RESP, 4'h9, 1'b1);
        rsp = 4'h9;
        `CHK(resp_ms, 14'(msx[rsp]))
        code(sts_pkg::SEC_OFFS, 4'hf, 1'b0);
        op.switches(1'b1, sts_pkg::SEC_HYST);
        op.press(4'h0);
        op.switches(1'b1, sts_pkg::SEC_OFFS);
        rd(sts_pkg::ADDR_CODES, {20'h0, hys, ofs, rsp});
        for (int k = 0; k < 10; k++) begin
            ofs = 4'(9 - k);
            hys = k[3:0];
            code(sts_pkg::SEC_OFFS, ofs, 1'b1);
            code(sts_pkg::SEC_HYST, hys, 1'b1);
            rd(sts_pkg::ADDR_CODES, {20'h0, hys, ofs, rsp});
            pts();
        end
        op.switches(1'b0, 3'h0);
        for (int u = 0; u < 2; u++) begin
            over = (u == 0);
            apb(1'b1, sts_pkg::ADDR_CTRL, {31'h0, ~over});
            rd(sts_pkg::ADDR_CTRL, {31'h0, ~over});
            pts();
            probe(over ? tp + 1 : tp - 1, 1'b1);
            probe((tp + rp) / 2, 1'b1);
            probe(over ? rp - 1 : rp + 1, 1'b0);
        end
        wrap_up();
    end
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        errors++;
        wrap_up();
    end
endmodule // testbench
